// [core/rspd_avg.v]
// four-sample block averager of the converter stream
`timescale 1ns/1ps
`default_nettype none
`include "rspd_defs.vh"
module rspd_avg #(
  parameter WIDTH = 8
) (
  input wire clk_i, // system clock
  input wire rst_b_i, // async reset, active low
  input wire ce_i, // clock enable
  input wire [WIDTH-1:0] sample_i, // converter result
  input wire sample_valid_i, // one-cycle sample strobe
  output reg [WIDTH-1:0] avg_o, // truncated average
  output reg avg_valid_o // one-cycle, once per group of four
);
  reg [WIDTH+1:0] sum_q;
  reg [1:0] cnt_q;
  wire [WIDTH+1:0] sum_d;

  assign sum_d = sum_q + {2'b00, sample_i};

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sum_q <= {(WIDTH+2){1'b0}};
      cnt_q <= 2'd0;
      avg_o <= {WIDTH{1'b0}};
      avg_valid_o <= 1'b0;
    end else if (ce_i) begin
      avg_valid_o <= 1'b0;
      if (sample_valid_i) begin
        if (cnt_q == 2'd3) begin
          // divide by four by dropping two bits
          avg_o <= sum_d[WIDTH+1:2];
          avg_valid_o <= 1'b1;
          sum_q <= {(WIDTH+2){1'b0}};
        end else begin
          sum_q <= sum_d;
        end
        cnt_q <= cnt_q + 2'd1;
      end
    end
  end
endmodule
`default_nettype wire

// [core/rspd_top.v]
// signal-strength peak readout with spi register access
// Summary of operation
// - 8-bit converter result feeds peak logic
// - average level over four samples
// - two independent peak detectors, same stream
// - telegram detector observes from sync to end
// - frame sync clears telegram running peak
// - end of message copies telegram peak
// - observation start delayed by bit count
// - sync and end events lag data
// - telegram peak cleared only by reset
// - running detector tracks only while receiver runs
// - higher averaged level replaces running peak
// - read refreshes register and restarts detector
// - read while idle keeps detector value
// - running peak register resets to zero
// - bits 6:5 select monitor pin signal
// - bit 4 enables monitor pin buffer
// - bits 3:0 set offset trim
// - bits 2:1 select anti-alias corner
// - converter scales strength ratio onto 0..255
// - bit 0 inverts manchester data polarity
`timescale 1ns/1ps
`default_nettype none
`include "rspd_defs.vh"
module rspd_top #(
  parameter WIDTH = 8,
  parameter LAG_BITS = `RSPD_EVENT_LAG_BITS,
  parameter DELAY_W = 8
) (
  input wire clk_i, // 200 mhz system clock
  input wire rst_b_i, // power-up reset, async, active low
  input wire ce_i, // clock enable, freezes all state when low
  input wire spi_sclk_i, // spi clock pin
  input wire spi_cs_b_i, // spi chip select pin, active low
  input wire spi_mosi_i, // spi data in pin
  output reg spi_miso_o, // spi data out
  output wire spi_miso_oe_o, // spi data out enable
  input wire [WIDTH-1:0] adc_sample_i, // scaled strength from converter
  input wire adc_valid_i, // one-cycle converter strobe
  input wire frame_sync_event_i, // one-cycle frame sync pulse
  input wire end_of_message_event_i, // one-cycle end of message pulse
  input wire bit_tick_i, // one-cycle pulse per data bit
  input wire rx_run_i, // receiver running level
  input wire cfg_sel_b_i, // selects configuration set b
  input wire [DELAY_W-1:0] peak_start_bit_delay_i, // bits to wait after sync
  output wire [1:0] monitor_signal_select_o, // monitor pin source
  output wire monitor_buffer_enable_o, // monitor pin buffer on
  output wire [3:0] strength_offset_trim_o, // offset trim
  output wire [1:0] anti_alias_corner_select_o, // filter corner
  output wire data_polarity_invert_o, // invert data polarity
  output wire [WIDTH-1:0] avg_level_o, // averaged level
  output wire telegram_active_o // telegram detector observing
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_OBS = 2'd2;

  // ---------------- pin synchronisers, three stages ----------------
  reg [2:0] sclk_s_q;
  reg [2:0] cs_s_q;
  reg [2:0] mosi_s_q;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_s_q <= 3'b000;
      cs_s_q <= 3'b111;
      mosi_s_q <= 3'b000;
    end else if (ce_i) begin
      sclk_s_q <= {sclk_s_q[1:0], spi_sclk_i};
      cs_s_q <= {cs_s_q[1:0], spi_cs_b_i};
      mosi_s_q <= {mosi_s_q[1:0], spi_mosi_i};
    end
  end

  // a change counts once stages two and three agree
  reg sclk_lvl_q;
  reg cs_lvl_q;
  reg mosi_lvl_q;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_lvl_q <= 1'b0;
      cs_lvl_q <= 1'b1;
      mosi_lvl_q <= 1'b0;
    end else if (ce_i) begin
      if (sclk_s_q[1] == sclk_s_q[2]) begin
        sclk_lvl_q <= sclk_s_q[2];
      end
      if (cs_s_q[1] == cs_s_q[2]) begin
        cs_lvl_q <= cs_s_q[2];
      end
      if (mosi_s_q[1] == mosi_s_q[2]) begin
        mosi_lvl_q <= mosi_s_q[2];
      end
    end
  end

  wire sclk_now;
  wire cs_now;
  wire sclk_rise;
  wire sclk_fall;
  wire sel;
  assign sclk_now = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_lvl_q;
  assign cs_now = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_lvl_q;
  assign sel = !cs_now;
  assign sclk_rise = sel && sclk_now && !sclk_lvl_q;
  assign sclk_fall = sel && !sclk_now && sclk_lvl_q;
  assign spi_miso_oe_o = !cs_lvl_q;

  // ---------------- averager ----------------
  wire [WIDTH-1:0] avg;
  wire avg_valid;
  rspd_avg #(.WIDTH(WIDTH)) u_avg (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .sample_i(adc_sample_i),
    .sample_valid_i(adc_valid_i),
    .avg_o(avg),
    .avg_valid_o(avg_valid)
  );
  assign avg_level_o = avg;

  // ---------------- event lag, in data bits ----------------
  wire [1:0] ev_in;
  wire [1:0] ev_out;
  assign ev_in = {end_of_message_event_i, frame_sync_event_i};
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lag
      reg pend_q;
      reg [3:0] lag_q;
      reg fire_q;
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          pend_q <= 1'b0;
          lag_q <= 4'd0;
          fire_q <= 1'b0;
        end else if (ce_i) begin
          fire_q <= 1'b0;
          if (ev_in[g]) begin
            pend_q <= 1'b1;
            lag_q <= 4'd0;
          end else if (pend_q && bit_tick_i) begin
            if (lag_q == LAG_BITS[3:0] - 4'd1) begin
              pend_q <= 1'b0;
              fire_q <= 1'b1;
            end else begin
              lag_q <= lag_q + 4'd1;
            end
          end
        end
      end
      assign ev_out[g] = (LAG_BITS == 0) ? ev_in[g] : fire_q;
    end
  endgenerate
  wire frame_sync_event_lag;
  wire eom_lag;
  assign frame_sync_event_lag = ev_out[0];
  assign eom_lag = ev_out[1];

  // ---------------- telegram peak detector ----------------
  reg [1:0] tel_st_q;
  reg [DELAY_W-1:0] tel_cnt_q;
  reg [WIDTH-1:0] tel_run_q;
  reg [WIDTH-1:0] telegram_peak_level_q;
  wire tel_hit;
  assign tel_hit = avg_valid && (tel_st_q == ST_OBS) && (avg > tel_run_q);
  assign telegram_active_o = (tel_st_q == ST_OBS);

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tel_st_q <= ST_IDLE;
      tel_cnt_q <= {DELAY_W{1'b0}};
      tel_run_q <= {WIDTH{1'b0}};
      telegram_peak_level_q <= `RSPD_RST_PEAK;
    end else if (ce_i) begin
      if (frame_sync_event_lag) begin
        tel_run_q <= {WIDTH{1'b0}};
        tel_cnt_q <= {DELAY_W{1'b0}};
        if (peak_start_bit_delay_i == {DELAY_W{1'b0}}) begin
          tel_st_q <= ST_OBS;
        end else begin
          tel_st_q <= ST_WAIT;
        end
      end else if (eom_lag) begin
        if (tel_st_q != ST_IDLE) begin
          telegram_peak_level_q <= tel_hit ? avg : tel_run_q;
        end
        tel_st_q <= ST_IDLE;
      end else begin
        case (tel_st_q)
          ST_IDLE: begin
            tel_cnt_q <= {DELAY_W{1'b0}};
          end
          ST_WAIT: begin
            if (bit_tick_i) begin
              if (tel_cnt_q == peak_start_bit_delay_i - {{(DELAY_W-1){1'b0}}, 1'b1}) begin
                tel_st_q <= ST_OBS;
              end else begin
                tel_cnt_q <= tel_cnt_q + {{(DELAY_W-1){1'b0}}, 1'b1};
              end
            end
          end
          ST_OBS: begin
            if (tel_hit) begin
              tel_run_q <= avg;
            end
          end
          default: begin
            tel_st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------- spi frame: command, address, data ----------------
  reg [4:0] bit_cnt_q;
  reg [7:0] sh_in_q;
  reg [7:0] cmd_q;
  reg [7:0] addr_q;
  reg [7:0] sh_out_q;
  reg [7:0] trim_mon_q;
  reg [7:0] glob_a_q;
  reg [7:0] glob_b_q;
  reg [WIDTH-1:0] run_det_q;
  reg [WIDTH-1:0] running_peak_level_q;

  wire [7:0] sh_in_d;
  wire hdr_done;
  wire wr_done;
  wire rd_run_peak;
  wire run_hit;
  wire [WIDTH-1:0] run_now;
  assign sh_in_d = {sh_in_q[6:0], mosi_lvl_q};
  assign hdr_done = sclk_rise && (bit_cnt_q == `RSPD_SPI_HDR_BITS - 5'd1);
  assign wr_done = sclk_rise && (bit_cnt_q == `RSPD_SPI_BITS - 5'd1)
    && (cmd_q == `RSPD_CMD_WRITE);
  assign rd_run_peak = hdr_done && (cmd_q == `RSPD_CMD_READ)
    && (sh_in_d == `RSPD_ADDR_RUN_PEAK);
  assign run_hit = rx_run_i && avg_valid && (avg > run_det_q);
  assign run_now = run_hit ? avg : run_det_q;

  // read decode, shared by the shift loader
  function [7:0] rspd_rdata;
    input [7:0] a;
    input [WIDTH-1:0] tel;
    input [WIDTH-1:0] run;
    begin
      case (a)
        `RSPD_ADDR_TEL_PEAK: rspd_rdata = tel;
        `RSPD_ADDR_RUN_PEAK: rspd_rdata = run;
        default: rspd_rdata = 8'h00;
      endcase
    end
  endfunction

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_q <= 5'd0;
      sh_in_q <= 8'h00;
      cmd_q <= 8'h00;
      addr_q <= 8'h00;
      sh_out_q <= 8'h00;
      spi_miso_o <= 1'b0;
    end else if (ce_i) begin
      if (!sel) begin
        bit_cnt_q <= 5'd0;
      end else begin
        if (sclk_rise) begin
          sh_in_q <= sh_in_d;
          if (bit_cnt_q != `RSPD_SPI_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'd1;
          end
          if (bit_cnt_q == 5'd7) begin
            cmd_q <= sh_in_d;
          end
          if (hdr_done) begin
            addr_q <= sh_in_d;
            sh_out_q <= rspd_rdata(sh_in_d, telegram_peak_level_q, run_now);
          end
        end
        if (sclk_fall) begin
          spi_miso_o <= sh_out_q[7];
          sh_out_q <= {sh_out_q[6:0], 1'b0};
        end
      end
    end
  end

  // ---------------- configuration registers, write only ----------------
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trim_mon_q <= `RSPD_RST_TRIM_MON;
      glob_a_q <= `RSPD_RST_GLOB;
      glob_b_q <= `RSPD_RST_GLOB;
    end else if (ce_i && wr_done) begin
      case (addr_q)
        `RSPD_ADDR_TRIM_MON: trim_mon_q <= sh_in_d;
        `RSPD_ADDR_GLOB_A: glob_a_q <= sh_in_d;
        `RSPD_ADDR_GLOB_B: glob_b_q <= sh_in_d;
        default: trim_mon_q <= trim_mon_q;
      endcase
    end
  end

  wire [7:0] glob;
  assign glob = cfg_sel_b_i ? glob_b_q : glob_a_q;
  assign monitor_signal_select_o = trim_mon_q[`RSPD_MON_SEL_HI:`RSPD_MON_SEL_LO];
  assign monitor_buffer_enable_o = trim_mon_q[`RSPD_MON_BUF_BIT];
  assign strength_offset_trim_o = trim_mon_q[`RSPD_OFFS_HI:`RSPD_OFFS_LO];
  assign anti_alias_corner_select_o = glob[`RSPD_AAF_HI:`RSPD_AAF_LO];
  assign data_polarity_invert_o = glob[`RSPD_INV_BIT];

  // ---------------- free-running peak detector ----------------
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_det_q <= {WIDTH{1'b0}};
      running_peak_level_q <= `RSPD_RST_PEAK;
    end else if (ce_i) begin
      if (rd_run_peak && rx_run_i) begin
        running_peak_level_q <= run_now;
        // a sample above the detector landing on the read cycle starts the next window
        run_det_q <= run_hit ? avg : {WIDTH{1'b0}};
      end else if (run_hit) begin
        run_det_q <= avg;
      end
      // idle reads leave the detector untouched
      if (rd_run_peak && !rx_run_i) begin
        running_peak_level_q <= run_det_q;
      end
    end
  end

endmodule
`default_nettype wire

// [inc/rspd_defs.vh]
// register map, field positions, reset values and frame constants of the peak readout
`ifndef RSPD_DEFS_VH
`define RSPD_DEFS_VH

`define RSPD_ADDR_TRIM_MON 8'h1c
`define RSPD_ADDR_GLOB_A 8'h6c
`define RSPD_ADDR_GLOB_B 8'h8c
`define RSPD_ADDR_TEL_PEAK 8'hac
`define RSPD_ADDR_RUN_PEAK 8'had

`define RSPD_RST_TRIM_MON 8'h15
`define RSPD_RST_GLOB 8'h00
`define RSPD_RST_PEAK 8'h00

`define RSPD_MON_SEL_HI 6
`define RSPD_MON_SEL_LO 5
`define RSPD_MON_BUF_BIT 4
`define RSPD_OFFS_HI 3
`define RSPD_OFFS_LO 0
`define RSPD_AAF_HI 2
`define RSPD_AAF_LO 1
`define RSPD_INV_BIT 0

`define RSPD_CMD_WRITE 8'h02
`define RSPD_CMD_READ 8'h03
`define RSPD_SPI_BITS 5'd24
`define RSPD_SPI_HDR_BITS 5'd16

`define RSPD_AVG_SAMPLES 3'd4
`define RSPD_EVENT_LAG_BITS 2

`endif

// [verif/rspd_checker.sv]
// port assertions of the peak readout
`timescale 1ns/1ps
`default_nettype none
module rspd_checker (
  input wire logic clk_i, // clock
  input wire logic rst_b_i, // reset
  input wire logic spi_cs_b_i, // select
  input wire logic spi_miso_oe_o, // miso enable
  input wire logic adc_valid_i, // strobe
  input wire logic bit_tick_i, // bit pulse
  input wire logic cfg_sel_b_i, // set b
  input wire logic [1:0] monitor_signal_select_o, // source
  input wire logic monitor_buffer_enable_o, // buffer
  input wire logic [3:0] strength_offset_trim_o, // trim
  input wire logic [1:0] anti_alias_corner_select_o, // corner
  input wire logic data_polarity_invert_o, // polarity
  input wire logic [7:0] avg_level_o, // average
  input wire logic telegram_active_o // observing
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_oe_idle:
    assert property (spi_cs_b_i [*5] |-> !spi_miso_oe_o) else $error("miso enabled idle");
  chk_oe_active:
    assert property (!spi_cs_b_i [*5] |-> spi_miso_oe_o) else $error("miso not enabled");
  chk_trim_reset:
    assert property ($rose(rst_b_i) |-> {monitor_signal_select_o, monitor_buffer_enable_o,
      strength_offset_trim_o} == 7'h15) else $error("trim reset value");
  chk_idle_reset:
    assert property ($rose(rst_b_i) |-> !telegram_active_o && avg_level_o == 8'h00)
      else $error("detector reset state");
  chk_avg_cause:
    assert property ($changed(avg_level_o) |-> $past(adc_valid_i) || $past(adc_valid_i, 2))
      else $error("average moved without sample");
  chk_tel_edge:
    assert property ($changed(telegram_active_o) |-> $past(bit_tick_i) || $past(bit_tick_i, 2))
      else $error("observe state moved off bit");
  chk_cfg_hold:
    assert property ((spi_cs_b_i && $stable(cfg_sel_b_i)) [*5] ##1 $stable(cfg_sel_b_i) |->
      $stable({anti_alias_corner_select_o, data_polarity_invert_o})) else $error("cfg moved");
  chk_trim_hold:
    assert property (spi_cs_b_i [*5] |=> $stable({monitor_signal_select_o,
      monitor_buffer_enable_o, strength_offset_trim_o})) else $error("trim moved");
  cover property ($rose(telegram_active_o));
  cover property ($fell(spi_cs_b_i) ##[1:600] $rose(spi_cs_b_i));
  cover property ($changed(avg_level_o));
endmodule
bind rspd_top rspd_checker u_chk (.clk_i, .rst_b_i, .spi_cs_b_i, .spi_miso_oe_o, .adc_valid_i,
  .bit_tick_i, .cfg_sel_b_i, .monitor_signal_select_o, .monitor_buffer_enable_o,
  .strength_offset_trim_o, .anti_alias_corner_select_o, .data_polarity_invert_o,
  .avg_level_o, .telegram_active_o);
`default_nettype wire

// [verif/rspd_host.sv]
// spi host model issuing register frames
`timescale 1ns/1ps
`default_nettype none
module rspd_host (
  input wire logic clk_i, // clock
  input wire logic miso_i, // device data
  output var logic sclk_o, // spi clock
  output var logic cs_b_o, // select
  output var logic mosi_o // host data
);
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    mosi_o = 1'b0;
  end
  // mode 0, msb first, 10 clocks a half period; sclk stands still between frames
  task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] r);
    logic [23:0] w;
    w = {c, a, d};
    r = 8'h00;
    @(posedge clk_i);
    cs_b_o <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi_o <= w[i];
      repeat (10) @(posedge clk_i);
      sclk_o <= 1'b1;
      r = {r[6:0], miso_i};
      repeat (10) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (10) @(posedge clk_i);
    cs_b_o <= 1'b1;
    mosi_o <= ~w[0];
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [verif/rspd_top_test.sv]
// self-checking bench of the peak readout
`timescale 1ns/1ps
`default_nettype none
module rspd_top_test;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sclk, cs_b, mosi, miso, mon_buf, inv, tel_act;
  logic adc_valid = 1'b0, sync = 1'b0, end_of_message_event = 1'b0, tick = 1'b0, run = 1'b0, sel_b = 1'b0;
  logic [7:0] adc = 8'h00, pdelay = 8'h01, rd, avg;
  logic [1:0] mon_sel, corner;
  logic [3:0] offs;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic ce = 1'b1;
  // rf path control lives outside this block; offset is arbitrary and unmapped here
  localparam logic [7:0] RF_PATH_CONTROL_ADDR = 8'h07;
  always #2.5 clk_i = ~clk_i;
  rspd_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .spi_sclk_i(sclk),
    .spi_cs_b_i(cs_b), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(),
    .adc_sample_i(adc), .adc_valid_i(adc_valid), .frame_sync_event_i(sync),
    .end_of_message_event_i(end_of_message_event), .bit_tick_i(tick), .rx_run_i(run), .cfg_sel_b_i(sel_b),
    .peak_start_bit_delay_i(pdelay), .monitor_signal_select_o(mon_sel),
    .monitor_buffer_enable_o(mon_buf), .strength_offset_trim_o(offs),
    .anti_alias_corner_select_o(corner), .data_polarity_invert_o(inv),
    .avg_level_o(avg), .telegram_active_o(tel_act));
  rspd_host host (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(8'h02, a, d, rd);
  endtask
  task automatic rdr(input logic [7:0] a);
    host.xfer(8'h03, a, 8'h00, rd);
  endtask
  // m is {sync, end of message, bit tick}
  task automatic ev(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk_i);
      {sync, end_of_message_event, tick} <= m;
      @(posedge clk_i);
      {sync, end_of_message_event, tick} <= 3'b000;
      repeat (2) @(posedge clk_i);
    end
  endtask
  task automatic feed(input logic [7:0] v);
    repeat (4) begin
      @(posedge clk_i);
      adc <= v;
      adc_valid <= 1'b1;
      @(posedge clk_i);
      adc_valid <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_reset;
    check({1'b0, mon_sel, mon_buf, offs}, 8'h15);
    check({5'h00, corner, inv}, 8'h00);
    rdr(8'hac);
    check(rd, 8'h00);
    rdr(8'had);
    check(rd, 8'h00);
  endtask
  task automatic t_trim;
    for (int i = 0; i < 4; i++) begin
      wr(8'h1c, {1'b0, i[1:0], 5'h15});
      check({1'b0, mon_sel, mon_buf, offs}, {1'b0, i[1:0], 5'h15});
    end
    wr(8'h1c, 8'h0f);
    check({3'h0, mon_buf, offs}, 8'h0f);
    host.xfer(8'h07, 8'h1c, 8'h10, rd);
    check({3'h0, mon_buf, offs}, 8'h0f);
    rdr(8'h1c);
    check(rd, 8'h00);
  endtask
  task automatic t_glob;
    for (int i = 0; i < 4; i++) begin
      wr(8'h6c, {5'h00, i[1:0], i[0]});
      check({5'h00, corner, inv}, {5'h00, i[1:0], i[0]});
    end
    wr(8'h8c, 8'h05);
    sel_b <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({5'h00, corner, inv}, 8'h05);
    sel_b <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({5'h00, corner, inv}, 8'h07);
  endtask
  task automatic t_avg;
    logic [7:0] s [8] = '{8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'hff, 8'hff, 8'hff, 8'hfe};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      adc <= s[i];
      adc_valid <= 1'b1;
      if (i == 6) check(avg, 8'h0b);
    end
    @(posedge clk_i);
    adc_valid <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(avg, 8'hfe);
    // samples offered while the clock enable is low must leave no trace
    ce <= 1'b0;
    feed(8'h11);
    ce <= 1'b1;
    check(avg, 8'hfe);
  endtask
  task automatic t_run;
    run <= 1'b1;
    feed(8'h40);
    feed(8'h80);
    feed(8'h30);
    rdr(8'had);
    check(rd, 8'h80);
    feed(8'h20);
    rdr(8'had);
    check(rd, 8'h20);
    feed(8'h44);
    run <= 1'b0;
    feed(8'h90);
    rdr(8'had);
    check(rd, 8'h44);
    rdr(8'had);
    check(rd, 8'h44);
  endtask
  task automatic t_tel;
    ev(3'b100, 1);
    ev(3'b001, 1);
    feed(8'hc0);
    ev(3'b001, 1);
    feed(8'ha0);
    check({7'h00, tel_act}, 8'h00);
    ev(3'b001, 1);
    check({7'h00, tel_act}, 8'h01);
    feed(8'h60);
    ev(3'b010, 1);
    feed(8'h70);
    ev(3'b001, 2);
    check({7'h00, tel_act}, 8'h00);
    rdr(8'hac);
    check(rd, 8'h70);
    ev(3'b100, 1);
    ev(3'b001, 3);
    rdr(8'hac);
    check(rd, 8'h70);
    feed(8'h30);
    ev(3'b010, 1);
    ev(3'b001, 2);
    rdr(8'hac);
    check(rd, 8'h30);
    pdelay <= 8'h00;
    ev(3'b100, 1);
    ev(3'b001, 2);
    check({7'h00, tel_act}, 8'h01);
    feed(8'h50);
    ev(3'b010, 1);
    ev(3'b001, 2);
    rdr(8'hac);
    check(rd, 8'h50);
  endtask
  // eleven running peak reads, first dropped, mean of the last ten; gap shortened
  task automatic rd11(input logic [7:0] lvl, output logic [7:0] mean);
    int sum;
    sum = 0;
    for (int k = 0; k < 11; k++) begin
      feed(k == 0 ? 8'h80 : lvl + 8'(k % 2));
      rdr(8'had);
      if (k > 0) sum += rd;
    end
    mean = 8'(sum / 10);
  endtask
  task automatic t_trim_seq;
    logic [7:0] mean;
    run <= 1'b1;
    wr(RF_PATH_CONTROL_ADDR, 8'h1f);
    check({1'b0, mon_sel, mon_buf, offs}, 8'h0f);
    wr(8'h1c, 8'h10);
    rd11(8'h01, mean);
    check(mean, 8'h01);
    if (mean < 8'h02) wr(8'h1c, 8'h12);
    rd11(8'h04, mean);
    check(mean, 8'h04);
    check({4'h0, offs}, 8'h02);
    rd11(8'hfc, mean);
    check(mean, 8'hfc);
  endtask
  task automatic conclude;
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      fail_count++;
      conclude;
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    t_reset;
    t_trim;
    t_glob;
    t_avg;
    t_run;
    t_tel;
    t_trim_seq;
    conclude;
  end
endmodule
`default_nettype wire
